// ### lcd_pkg.sv
/*
  Constants shared by the LCD two-wire command front end: slave address,
  command opcodes, reset values, pointer limits and FIFO shape.
  Assumes the user writes every use as lcd_pkg::name.
*/
package lcd_pkg;
  localparam logic [5:0] SLV_ADDR_HI    = 6'h1C;  // 011100
  localparam logic [3:0] OP_MODE_SET    = 4'hC;
  localparam logic [3:0] OP_PTR_MSB     = 4'h0;
  localparam logic [3:0] OP_PTR_LSB     = 4'h4;
  localparam logic [5:0] OP_DEV_SEL     = 6'h38;
  localparam logic [5:0] OP_BANK_SEL    = 6'h3E;
  localparam logic [4:0] OP_BLINK_SEL   = 5'h1E;
  localparam logic [4:0] OP_PRESCALE    = 5'h1D;
  localparam int         CTRL_CONT_BIT  = 7;
  localparam int         CTRL_RS_BIT    = 6;
  localparam logic [1:0] MODE_STATIC    = 2'h1;
  localparam logic [1:0] MODE_MUX2      = 2'h2;
  localparam logic [1:0] MODE_RESET     = 2'h0;
  localparam logic [2:0] PRESCALE_RESET = 3'h3;
  localparam logic [7:0] PTR_LAST       = 8'h9F;  // 160 addresses
  localparam logic [3:0] BIT_LAST       = 4'h7;
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam int         FIFO_DEPTH     = 16;
  localparam int         FIFO_WIDTH     = 17;     // pointer, bank, byte

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SKIP} lcd_bus_st_t;
  typedef enum logic [1:0] {K_ADDR, K_CTRL, K_CMD, K_DATA} lcd_kind_t;

  // divider N of the frame rate for each prescaler code
  function automatic logic [6:0] lcd_frame_div(input logic [2:0] code);
    case (code)
      3'h0:    lcd_frame_div = 7'h50;  // 80
      3'h1:    lcd_frame_div = 7'h4A;  // 74
      3'h2:    lcd_frame_div = 7'h44;  // 68
      3'h4:    lcd_frame_div = 7'h3C;  // 60
      3'h5:    lcd_frame_div = 7'h38;  // 56
      3'h6:    lcd_frame_div = 7'h35;  // 53
      default: lcd_frame_div = 7'h40;  // 64 for 011 and 111
    endcase
  endfunction
endpackage

// ### lcd_fifo_if.sv
/*
  Valid/ready carrier between the command front end and its write FIFO.
  Assumes one producer and one consumer on the same clock.
*/
`timescale 1ns/1ps
interface lcd_fifo_if #(parameter int WIDTH = lcd_pkg::FIFO_WIDTH);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
endinterface

// ### lcd_fifo.sv
/*
  Synchronous FIFO for display bytes waiting for the RAM port.
  Assumes one clock; clock enable low freezes all state.
*/
`timescale 1ns/1ps
module lcd_fifo #(
  parameter int WIDTH = lcd_pkg::FIFO_WIDTH,
  parameter int DEPTH = lcd_pkg::FIFO_DEPTH
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  lcd_fifo_if.fifo  port_if
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  // honest flags straight from the occupancy count
  assign port_if.push_ready = (count != (AW+1)'(DEPTH));
  assign port_if.pop_valid  = (count != '0);
  assign port_if.pop_data   = mem[rd_ptr];
  assign do_push = port_if.push_valid & port_if.push_ready & ce_in;
  assign do_pop  = port_if.pop_valid & port_if.pop_ready & ce_in;

  // storage array, no reset needed
  always_ff @(posedge clk_in)
  begin
    if (do_push)
      mem[wr_ptr] <= port_if.push_data;
  end

  // pointers and count
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (do_push && !do_pop)
        count <= count + 1'b1;
      else if (do_pop && !do_push)
        count <= count - 1'b1;
    end
  end
endmodule // lcd_fifo

// ### lcd_cmd_dec.sv
/*
  Write-only two-wire slave front end and command decoder of the LCD
  controller: status settings, data pointer, subaddress counter, and the
  display byte stream toward RAM through a 16-entry FIFO.
  Assumes bus pins and straps are asynchronous and the bus clock is far
  slower than clk_in; the ack pin is open drain, resolved outside.
*/
`timescale 1ns/1ps
module lcd_cmd_dec (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       addr_select_pin_in,
  input  wire logic       subaddr_pin_lo_in,
  input  wire logic       subaddr_pin_hi_in,
  input  wire logic       ram_wr_ready_in,
  output logic            ack_output_pin_out,
  output logic            ack_output_pin_oe_n_out,
  output logic            display_en_out,
  output logic            blank_out,
  output logic            clk_pin_drive_out,
  output logic            bias_half_out,
  output logic [1:0]      drive_mode_out,
  output logic [7:0]      data_ptr_out,
  output logic [1:0]      sub_cnt_out,
  output logic            in_bank_out,
  output logic            out_bank_out,
  output logic            alt_bank_blink_bit_out,
  output logic            blink_alt_eff_out,
  output logic [1:0]      blink_rate_field_out,
  output logic [2:0]      prescale_code_out,
  output logic [6:0]      frame_div_out,
  output logic            ram_wr_valid_out,
  output logic [7:0]      ram_wr_addr_out,
  output logic            ram_wr_bank_out,
  output logic [7:0]      ram_wr_data_out
);
  lcd_pkg::lcd_bus_st_t state;
  lcd_pkg::lcd_kind_t   kind;
  lcd_pkg::lcd_kind_t   body_kind;
  logic [1:0]           scl_s;
  logic [1:0]           sda_s;
  logic [1:0]           sa0_s;
  logic [1:0]           alo_s;
  logic [1:0]           ahi_s;
  logic                 scl_d;
  logic                 sda_d;
  logic [3:0]           bit_cnt;
  logic [7:0]           sh;
  logic [7:0]           rx_byte;
  logic                 continue_flag;
  logic                 ack_want;
  logic                 cmd_stb;
  logic                 data_stb;
  logic                 data_match;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  logic                 byte_done;
  logic [7:0]           rx_full;
  logic                 sub_match;
  logic                 mux_3_4;
  lcd_fifo_if           wq_if ();

  // two flops on every pin; only the second stage is read
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      sa0_s <= 2'h0;
      alo_s <= 2'h0;
      ahi_s <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (ce_in)
    begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      sa0_s <= {sa0_s[0], addr_select_pin_in};
      alo_s <= {alo_s[0], subaddr_pin_lo_in};
      ahi_s <= {ahi_s[0], subaddr_pin_hi_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  // line events seen on the synchronised levels
  assign scl_rise  = scl_s[1] & ~scl_d;
  assign scl_fall  = ~scl_s[1] & scl_d;
  assign start_det = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_det  = scl_s[1] & scl_d & ~sda_d & sda_s[1];
  assign rx_full   = {sh[6:0], sda_s[1]};
  assign byte_done = (state == lcd_pkg::ST_RECV) && scl_rise && (bit_cnt == lcd_pkg::BIT_LAST);
  assign sub_match = (sub_cnt_out == {ahi_s[1], alo_s[1]});
  assign mux_3_4   = (drive_mode_out != lcd_pkg::MODE_STATIC) &&
                     (drive_mode_out != lcd_pkg::MODE_MUX2);

  // bus receiver: bit count, byte type and acknowledge decision
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state         <= lcd_pkg::ST_IDLE;
      kind          <= lcd_pkg::K_ADDR;
      body_kind     <= lcd_pkg::K_CMD;
      continue_flag <= 1'b0;
      bit_cnt       <= 4'h0;
      sh            <= 8'h00;
      rx_byte       <= 8'h00;
      ack_want      <= 1'b0;
      cmd_stb       <= 1'b0;
      data_stb      <= 1'b0;
      data_match    <= 1'b0;
      ack_output_pin_oe_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      cmd_stb  <= 1'b0;
      data_stb <= 1'b0;
      if (start_det)
      begin
        // a start, first or repeated, always reopens address reception
        state   <= lcd_pkg::ST_RECV;
        kind    <= lcd_pkg::K_ADDR;
        bit_cnt <= 4'h0;
        ack_output_pin_oe_n_out <= 1'b1;
      end
      else if (stop_det)
      begin
        state <= lcd_pkg::ST_IDLE;
        ack_output_pin_oe_n_out <= 1'b1;
      end
      else
      begin
        unique case (state)
          lcd_pkg::ST_IDLE, lcd_pkg::ST_SKIP: ;  // wait for a start
          lcd_pkg::ST_RECV:
          begin
            if (scl_rise)
            begin
              sh      <= rx_full;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_done)
            begin
              rx_byte  <= rx_full;
              ack_want <= 1'b1;
              unique case (kind)
                lcd_pkg::K_ADDR:
                begin
                  // wrong address, wrong select level or a read: stay silent
                  if (rx_full[7:2] != lcd_pkg::SLV_ADDR_HI ||
                      rx_full[1] != sa0_s[1] ||
                      rx_full[0])
                    state <= lcd_pkg::ST_SKIP;
                  kind <= lcd_pkg::K_CTRL;
                end
                lcd_pkg::K_CTRL:
                begin
                  continue_flag <= rx_full[lcd_pkg::CTRL_CONT_BIT];
                  body_kind <= rx_full[lcd_pkg::CTRL_RS_BIT] ? lcd_pkg::K_DATA
                                                            : lcd_pkg::K_CMD;
                  kind      <= rx_full[lcd_pkg::CTRL_RS_BIT] ? lcd_pkg::K_DATA
                                                            : lcd_pkg::K_CMD;
                end
                lcd_pkg::K_CMD:
                begin
                  cmd_stb <= 1'b1;
                  kind    <= continue_flag ? lcd_pkg::K_CTRL : body_kind;
                end
                lcd_pkg::K_DATA:
                begin
                  // full FIFO: refuse the byte by withholding the ack
                  ack_want   <= sub_match & wq_if.push_ready;
                  data_stb   <= ~sub_match | wq_if.push_ready;
                  data_match <= sub_match;
                  kind       <= continue_flag ? lcd_pkg::K_CTRL : body_kind;
                end
              endcase
            end
            else if (scl_fall && bit_cnt == lcd_pkg::BIT_ACK)
            begin
              state <= lcd_pkg::ST_ACK;
              ack_output_pin_oe_n_out <= ~ack_want;
            end
          end
          lcd_pkg::ST_ACK:
            if (scl_fall)
            begin
              ack_output_pin_oe_n_out <= 1'b1;
              bit_cnt <= 4'h0;
              state   <= lcd_pkg::ST_RECV;
            end
        endcase
      end
    end
  end

  // settings loaded by command bytes
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      display_en_out         <= 1'b0;
      bias_half_out          <= 1'b0;
      drive_mode_out         <= lcd_pkg::MODE_RESET;
      in_bank_out            <= 1'b0;
      out_bank_out           <= 1'b0;
      alt_bank_blink_bit_out <= 1'b0;
      blink_rate_field_out   <= 2'h0;
      prescale_code_out      <= lcd_pkg::PRESCALE_RESET;
    end
    else if (ce_in && cmd_stb)
    begin
      if (rx_byte[7:4] == lcd_pkg::OP_MODE_SET)
      begin
        display_en_out <= rx_byte[3];
        bias_half_out  <= rx_byte[2];
        drive_mode_out <= rx_byte[1:0];
      end
      else if (rx_byte[7:2] == lcd_pkg::OP_BANK_SEL && !mux_3_4)
      begin
        in_bank_out  <= rx_byte[1];
        out_bank_out <= rx_byte[0];
      end
      else if (rx_byte[7:3] == lcd_pkg::OP_BLINK_SEL)
      begin
        alt_bank_blink_bit_out <= rx_byte[2];
        blink_rate_field_out   <= rx_byte[1:0];
      end
      else if (rx_byte[7:3] == lcd_pkg::OP_PRESCALE)
        prescale_code_out <= rx_byte[2:0];
      // any other pattern falls through with no change
    end
  end

  // values derived from settings, registered to keep outputs on flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      blank_out         <= 1'b1;
      clk_pin_drive_out <= 1'b0;
      blink_alt_eff_out <= 1'b0;
      frame_div_out     <= 7'h40;
    end
    else if (ce_in)
    begin
      blank_out         <= ~display_en_out;
      clk_pin_drive_out <= display_en_out;
      blink_alt_eff_out <= alt_bank_blink_bit_out & ~mux_3_4;
      frame_div_out     <= lcd_pkg::lcd_frame_div(prescale_code_out);
    end
  end

  // data pointer and subaddress counter; queue matching display bytes
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_ptr_out      <= 8'h00;
      sub_cnt_out       <= 2'h0;
      wq_if.push_valid  <= 1'b0;
      wq_if.push_data   <= '0;
    end
    else if (ce_in)
    begin
      wq_if.push_valid <= 1'b0;
      if (cmd_stb)
      begin
        if (rx_byte[7:4] == lcd_pkg::OP_PTR_MSB)
          data_ptr_out[7:4] <= rx_byte[3:0];
        else if (rx_byte[7:4] == lcd_pkg::OP_PTR_LSB)
          data_ptr_out[3:0] <= rx_byte[3:0];
        else if (rx_byte[7:2] == lcd_pkg::OP_DEV_SEL)
          sub_cnt_out <= rx_byte[1:0];
      end
      else if (data_stb)
      begin
        wq_if.push_valid <= data_match;
        wq_if.push_data  <= {data_ptr_out, in_bank_out, rx_byte};
        // pointer moves even when the write is suppressed
        if (data_ptr_out >= lcd_pkg::PTR_LAST)
        begin
          data_ptr_out <= 8'h00;
          sub_cnt_out  <= sub_cnt_out + 2'h1;
        end
        else
          data_ptr_out <= data_ptr_out + 8'h01;
      end
    end
  end

  lcd_fifo u_fifo (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .port_if  (wq_if.fifo)
  );

  // output stage so the RAM port is driven from flops
  assign wq_if.pop_ready = ce_in & (~ram_wr_valid_out | ram_wr_ready_in);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ram_wr_valid_out   <= 1'b0;
      ram_wr_addr_out    <= 8'h00;
      ram_wr_bank_out    <= 1'b0;
      ram_wr_data_out    <= 8'h00;
      ack_output_pin_out <= 1'b0;  // open drain: only ever pulls low
    end
    else if (ce_in)
    begin
      if (wq_if.pop_ready)
      begin
        ram_wr_valid_out <= wq_if.pop_valid;
        {ram_wr_addr_out, ram_wr_bank_out, ram_wr_data_out} <= wq_if.pop_data;
      end
    end
  end

  sequence s_mode_cmd;
    byte_done && kind == lcd_pkg::K_CMD && rx_full[7:4] == lcd_pkg::OP_MODE_SET ##1 cmd_stb;
  endsequence

  a_ack_after_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(ack_output_pin_oe_n_out) |-> $past(bit_cnt) == lcd_pkg::BIT_ACK && ack_want)
    else $error("ack driven outside the ninth bit");
  a_addr_mismatch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_done && ce_in && kind == lcd_pkg::K_ADDR && rx_full[7:2] != lcd_pkg::SLV_ADDR_HI
    |=> state == lcd_pkg::ST_SKIP)
    else $error("foreign address not skipped");
  a_sel_mismatch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_done && ce_in && kind == lcd_pkg::K_ADDR && rx_full[1] != sa0_s[1]
    |=> state == lcd_pkg::ST_SKIP)
    else $error("select level mismatch not skipped");
  a_read_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_done && ce_in && kind == lcd_pkg::K_ADDR && rx_full[0] |=> state == lcd_pkg::ST_SKIP)
    else $error("read access answered");
  a_skip_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == lcd_pkg::ST_SKIP && !start_det && !stop_det |=> state == lcd_pkg::ST_SKIP
      && ack_output_pin_oe_n_out)
    else $error("skipped transfer left early");
  a_ctrl_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_done && ce_in && kind == lcd_pkg::K_CTRL
    |=> kind == ($past(rx_full[6]) ? lcd_pkg::K_DATA : lcd_pkg::K_CMD))
    else $error("control byte target wrong");
  a_cmd_acked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_done && ce_in && kind == lcd_pkg::K_CMD |=> ack_want && cmd_stb)
    else $error("command byte not acknowledged");
  a_data_nomatch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_done && ce_in && kind == lcd_pkg::K_DATA && !sub_match |=> !ack_want ##1 !wq_if.push_valid)
    else $error("unmatched data acknowledged or stored");
  a_mode_load: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    s_mode_cmd |=> drive_mode_out == $past(rx_byte[1:0]) && display_en_out == $past(rx_byte[3]))
    else $error("mode-set not applied");
  a_bank_locked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_stb && mux_3_4 |=> $stable(in_bank_out) && $stable(out_bank_out))
    else $error("bank changed in three/four-way mode");
  a_ptr_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    data_stb && ce_in && data_ptr_out == lcd_pkg::PTR_LAST
    |=> data_ptr_out == 8'h00 && sub_cnt_out == $past(sub_cnt_out) + 2'h1)
    else $error("pointer overflow mishandled");
endmodule // lcd_cmd_dec

// ### lcd_bus_master.sv
/*
  Two-wire bus master model that drives the LCD front end.
  Assumes sda_in is the resolved wire, pulled up when released.
*/
`timescale 1ns/1ps
module lcd_bus_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial scl_out = 1'b1;
  initial sda_out = 1'b1;
  // six cycles a phase, above the four the slave needs
  task automatic half();
    repeat (6) @(posedge clk_in);
  endtask
  // start or repeated start, clock left low
  task automatic start();
    sda_out <= 1'b1;
    half();
    scl_out <= 1'b1;
    half();
    sda_out <= 1'b0;
    half();
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    sda_out <= 1'b0;
    half();
    scl_out <= 1'b1;
    half();
    sda_out <= 1'b1;
    half();
  endtask
  // msb first, then free the line and look in the ninth high phase
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_out <= b[i];
      half();
      scl_out <= 1'b1;
      half();
      scl_out <= 1'b0;
    end
    sda_out <= 1'b1;
    half();
    scl_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    ack = ~sda_in;
    repeat (3) @(posedge clk_in);
    scl_out <= 1'b0;
  endtask
endmodule // lcd_bus_master

// ### tb.sv
/*
  Self-checking bench for lcd_cmd_dec: master model, RAM sink, scenarios.
  Assumes the design holds its own write FIFO of 16 entries.
*/
`timescale 1ns/1ps
module tb;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        sel = 1'b0;
  logic        rdy = 1'b0;
  logic [1:0]  asub = 2'h0;
  logic        av, oe_n, en, blank, clkd, bias, ib, ob, ab, eff, wv, wb;
  logic [1:0]  mode, sub, rate;
  logic [2:0]  pre;
  logic [6:0]  div;
  logic [7:0]  ptr, wa, wd;
  wire         scl, sda_m;
  wire         sda = sda_m & (oe_n | av);  // ack pulls the pulled-up wire low
  int          n_fail = 0;
  int          tests_run = 0;
  logic [16:0] wq[$];
  logic [6:0]  n_tab[8] = '{7'h50, 7'h4A, 7'h44, 7'h40, 7'h3C, 7'h38, 7'h35, 7'h40};
  logic [7:0]  dsq[10] = '{8'h70, 8'h80, 8'h09, 8'h80, 8'h4E, 8'h80, 8'hE0, 8'h40, 8'hA5, 8'h3C};
  logic [7:0]  fsq[8] = '{8'h70, 8'h80, 8'hE0, 8'h80, 8'h00, 8'h80, 8'h40, 8'h40};

  lcd_bus_master i_lcd_bus_master (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
  lcd_cmd_dec i_lcd_cmd_dec (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .scl_in(scl),
    .sda_in(sda), .addr_select_pin_in(sel), .subaddr_pin_lo_in(asub[0]),
    .subaddr_pin_hi_in(asub[1]),
    .ram_wr_ready_in(rdy), .ack_output_pin_out(av), .ack_output_pin_oe_n_out(oe_n),
    .display_en_out(en), .blank_out(blank), .clk_pin_drive_out(clkd), .bias_half_out(bias),
    .drive_mode_out(mode), .data_ptr_out(ptr), .sub_cnt_out(sub), .in_bank_out(ib),
    .out_bank_out(ob), .alt_bank_blink_bit_out(ab), .blink_alt_eff_out(eff),
    .blink_rate_field_out(rate), .prescale_code_out(pre), .frame_div_out(div),
    .ram_wr_valid_out(wv), .ram_wr_addr_out(wa), .ram_wr_bank_out(wb), .ram_wr_data_out(wd));

  always #2 clk_in = ~clk_in;
  // ram sink; refuses whenever rdy is low
  always @(posedge clk_in)
  begin
    if (wv === 1'b1 && rdy === 1'b1)
      wq.push_back({wa, wb, wd});
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic exp);
    logic a;
    i_lcd_bus_master.put(b, a);
    chk(a, exp);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic t_reset();
    chk({en, bias, mode, ptr, sub}, 0);
    chk({blank, clkd, oe_n, av}, 4'b1010);
    chk({ib, ob, ab, rate, pre, div}, {5'h0, 3'h3, 7'h40});
  endtask
  // strap high: wrong bit 1, read, foreign address all ignored
  task automatic t_addr();
    sel <= 1'b1;
    i_lcd_bus_master.start();
    wr(8'h70, 1'b0);
    wr(8'hC8, 1'b0);
    chk(en, 0);
    i_lcd_bus_master.start();
    wr(8'h73, 1'b0);
    i_lcd_bus_master.start();
    wr(8'h62, 1'b0);
    i_lcd_bus_master.start();
    wr(8'h72, 1'b1);
    i_lcd_bus_master.stop();
    sel <= 1'b0;
  endtask
  task automatic t_cmds();
    i_lcd_bus_master.start();
    wr(8'h70, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'hCD, 1'b1);
    chk({en, bias, mode, blank, clkd}, 6'b110101);
    wr(8'h09, 1'b1);
    wr(8'h4F, 1'b1);
    wr(8'hE2, 1'b1);
    wr(8'hE4, 1'b1);
    chk({ptr, sub, mode, pre}, {8'h9F, 2'h2, 2'h1, 3'h3});
    for (int c = 0; c < 8; c++)
    begin
      wr({5'h1D, c[2:0]}, 1'b1);
      chk({pre, div}, {c[2:0], n_tab[c]});
    end
    wr(8'hF5, 1'b1);
    chk({ab, rate, eff}, 4'b1011);
    wr(8'hFA, 1'b1);
    wr(8'hC3, 1'b1);
    wr(8'hF9, 1'b1);
    chk({ib, ob, eff}, 3'b100);
    wr(8'hC9, 1'b1);
    i_lcd_bus_master.stop();
  endtask
  // wrap past the last address moves to the next device
  task automatic t_data();
    rdy <= 1'b1;
    wq.delete();
    i_lcd_bus_master.start();
    foreach (dsq[i]) wr(dsq[i], 1'b1);
    wr(8'h77, 1'b0);
    for (int k = 0; k < 100 && wq.size() < 2; k++) @(posedge clk_in);
    chk(wq.size(), 2);
    chk(wq[0], {8'h9E, 1'b1, 8'hA5});
    chk(wq[1], {8'h9F, 1'b1, 8'h3C});
    chk({ptr, sub}, {8'h01, 2'h1});
    // pins 01 match counter 1 only if lo is the low bit
    asub <= 2'h1;
    i_lcd_bus_master.start();
    wr(8'h70, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'hE4, 1'b1);
    i_lcd_bus_master.start();
    wr(8'h70, 1'b1);
    wr(8'h40, 1'b1);
    wr(8'h5A, 1'b1);
    i_lcd_bus_master.stop();
    asub <= 2'h0;
    for (int k = 0; k < 100 && wq.size() < 3; k++) @(posedge clk_in);
    chk(wq.size(), 3);
    chk(wq[2], {8'h01, 1'b1, 8'h5A});
    chk({ptr, sub}, {8'h02, 2'h1});
  endtask
  // fill while the sink stalls, then drain
  task automatic t_fifo();
    logic a;
    int   n;
    n = 0;
    rdy <= 1'b0;
    wq.delete();
    i_lcd_bus_master.start();
    foreach (fsq[i]) wr(fsq[i], 1'b1);
    for (int i = 0; i < 18; i++)
    begin
      i_lcd_bus_master.put(i[7:0], a);
      if (a === 1'b1)
        n++;
    end
    // the output register holds one byte beyond the 16 queued
    chk(n, 17);
    chk(ptr, 8'h11);
    i_lcd_bus_master.stop();
    rdy <= 1'b1;
    for (int k = 0; k < 200 && wq.size() < 17; k++) @(posedge clk_in);
    chk(wq.size(), 17);
    chk(wq[15], {8'h0F, 1'b1, 8'h0F});
    chk(wq[16], {8'h10, 1'b1, 8'h10});
    // one more edge so the cleared valid has landed
    @(posedge clk_in);
    chk(wv, 0);
  endtask

  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_addr();
    t_cmds();
    t_data();
    t_fifo();
    complete_run();
  end
  // watchdog well past the expected run
  initial
  begin
    #300000;
    n_fail++;
    complete_run();
  end
endmodule // tb
